// ===== pss_ctrl.sv
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
module pss_ctrl (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            arst_n,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic [31:0]          hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    // Power state and clock monitors
    input  wire logic            stop_req,
    input  wire pss_pkg::pss_sense_t sense,
    // Clock plant controls
    output logic                 pll_power_on,
    output logic                 osc_power_on,
    output pss_pkg::pss_mode_t   clock_mode,
    output logic                 reset_req,
    output logic                 sticky_lock_flag,
    output logic                 clock_loss_flag
);
    import pss_pkg::*;

    logic [31:0] ctrl_q;
    logic        stop_q;
    logic        wr_pend_q;
    logic [31:0] addr_q;
    pss_mode_t   mode_q;
    pss_mode_t   mode_d;
    pss_sense_t  sense_q;
    logic        rst_q;
    pss_cfg_t    cfg;

    assign cfg.stop_mode_select            = ctrl_q[`PSS_STOP_MODE_SELECT_LSB +: 2];
    assign cfg.loss_of_clock_detect_enable = ctrl_q[`PSS_LOSS_OF_CLOCK_DETECT_ENABLE_BIT];
    assign cfg.clock_loss_reset_enable     = ctrl_q[`PSS_CLOCK_LOSS_RESET_ENABLE_BIT];
    assign cfg.lock_loss_reset_enable      = ctrl_q[`PSS_LOCK_LOSS_RESET_ENABLE_BIT];
    assign cfg.fast_wakeup_select          = ctrl_q[`PSS_FAST_WAKEUP_SELECT_BIT];
    assign cfg.no_oscillator               = ctrl_q[`PSS_OSCREF_BIT];

    // Bus: zero wait states, always OKAY.
    wire addr_phase = hsel & hready & htrans[1];
    wire wr_ctrl    = wr_pend_q & (addr_q == `PSS_CTRL_OFS);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 32'h0000_0000;
        end else begin
            wr_pend_q <= addr_phase & hwrite;
            if (addr_phase) addr_q <= haddr;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) ctrl_q <= `PSS_CTRL_RST;
        else if (wr_ctrl) ctrl_q <= {25'h0, hwdata[6:0]};
    end

    wire [31:0] stat_word = {28'h0, mode_q, clock_loss_flag, sticky_lock_flag};
    wire [31:0] rd_word   = (haddr == `PSS_CTRL_OFS) ? ctrl_q :
                            (haddr == `PSS_STAT_OFS) ? stat_word : 32'h0000_0000;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) hrdata <= 32'h0000_0000;
        else if (addr_phase & ~hwrite) hrdata <= rd_word;
    end

    // Power during stop. Without an oscillator the OSC-on rows apply.
    wire pll_keep = (cfg.stop_mode_select < `PSS_STOP_MODE_SELECT_OSCON);
    wire osc_keep = (cfg.stop_mode_select <= `PSS_STOP_MODE_SELECT_OSCON);
    wire osc_eff  = cfg.no_oscillator ? 1'b1 : osc_keep;
    assign pll_power_on = ~stop_q | pll_keep;
    assign osc_power_on = ~cfg.no_oscillator & (~stop_q | osc_keep);

    wire lose_ref  = sense_q.ref_clk_ok & ~sense.ref_clk_ok;
    wire lose_fb   = sense_q.fb_clk_ok  & ~sense.fb_clk_ok;
    wire lose_lock = sense_q.pll_lock   & ~sense.pll_lock;
    wire stop_in   = stop_req & ~stop_q;
    // Reference losses while the oscillator is off in stop are only seen when a loss is recorded anyway.
    wire clk_lost  = lose_ref | lose_fb | (stop_q & ~osc_eff & lose_ref);

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            PSS_NORMAL_PLL_MODE: begin
                if (cfg.loss_of_clock_detect_enable) begin
                    if (lose_ref) mode_d = PSS_SELF_CLOCKED_MODE;
                    else if (lose_fb | lose_lock) mode_d = PSS_REFERENCE_MODE;
                end
            end
            default: mode_d = mode_q;
        endcase
    end

    wire rst_now = cfg.loss_of_clock_detect_enable & mode_q == PSS_NORMAL_PLL_MODE &
                   ((cfg.clock_loss_reset_enable & clk_lost) |
                    (cfg.lock_loss_reset_enable & lose_lock));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stop_q  <= 1'b0;
            mode_q  <= PSS_NORMAL_PLL_MODE;
            sense_q <= 3'b111;
            rst_q   <= 1'b0;
        end else begin
            stop_q  <= stop_req;
            mode_q  <= rst_now ? PSS_NORMAL_PLL_MODE : mode_d;
            sense_q <= sense;
            rst_q   <= rst_now;
        end
    end
    assign reset_req  = rst_q;
    assign clock_mode = mode_q;

    // Lock flag reads 0 while lock is lost; stays 0 if it never returns.
    pss_flag_keep u_lock (
        .clk        (clk),
        .arst_n     (arst_n),
        .live_val   (sense.pll_lock),
        .stop_enter (stop_in),
        .lost       (lose_lock),
        .regained   (~sense_q.pll_lock & sense.pll_lock),
        .forced_val (1'b0),
        .flag       (sticky_lock_flag)
    );

    // Clock-loss flag reads 1 until the clock returns.
    pss_flag_keep u_loss (
        .clk        (clk),
        .arst_n     (arst_n),
        .live_val   (1'b0),
        .stop_enter (stop_in),
        .lost       (clk_lost),
        .regained   (sense.ref_clk_ok & sense.fb_clk_ok & ~clk_lost),
        .forced_val (1'b1),
        .flag       (clock_loss_flag)
    );
endmodule // pss_ctrl
`default_nettype wire

// ===== pss_regs.svh
// Behaviour
// - The loop stays powered in stop only when the stop mode select field is 00 or 01.
// - The crystal oscillator runs in stop when the stop mode select field is 00, 01 or 10.
// - In one-to-one or external-reference normal mode the oscillator is off, and stop acts as if it were on.
// - Loss of the loop clock or its lock in normal mode falls back to reference mode.
// - Loss of the reference clock in normal mode switches to self-clocked mode.
// - After a lock loss the lock flag reads 0 until lock returns, then its pre-stop value.
// - Where lock never returns the lock flag stays 0.
// - After a clock loss the clock-loss flag reads 1 until the clock returns, then its pre-stop value.
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_CTRL_OFS      32'h0000_0000
`define PSS_STAT_OFS      32'h0000_0004
`define PSS_STOP_MODE_SELECT_LSB     0
`define PSS_LOSS_OF_CLOCK_DETECT_ENABLE_BIT     2
`define PSS_CLOCK_LOSS_RESET_ENABLE_BIT     3
`define PSS_LOCK_LOSS_RESET_ENABLE_BIT     4
`define PSS_FAST_WAKEUP_SELECT_BIT     5
`define PSS_OSCREF_BIT    6
`define PSS_CTRL_RST      32'h0000_0000
`define PSS_ST_LOCK_BIT   0
`define PSS_ST_LOSS_BIT   1
`define PSS_ST_MODE_LSB   2
`define PSS_STOP_MODE_SELECT_PLLON   2'h1
`define PSS_STOP_MODE_SELECT_OSCON   2'h2
`endif

// ===== pss_pkg.sv
package pss_pkg;
    typedef enum logic [1:0] {
        PSS_NORMAL_PLL_MODE,
        PSS_REFERENCE_MODE,
        PSS_SELF_CLOCKED_MODE,
        PSS_OUTSIDE_CLOCK_MODE
    } pss_mode_t;
    typedef struct packed {
        logic [1:0] stop_mode_select;
        logic       loss_of_clock_detect_enable;
        logic       clock_loss_reset_enable;
        logic       lock_loss_reset_enable;
        logic       fast_wakeup_select;
        logic       no_oscillator;
    } pss_cfg_t;
    typedef struct packed {
        logic ref_clk_ok;
        logic fb_clk_ok;
        logic pll_lock;
    } pss_sense_t;
endpackage : pss_pkg

// ===== pss_flag_keep.sv
`timescale 1ns/1ps
`default_nettype none
// Holds a status flag across stop: shows the forced value while the
// condition is open, then the value saved at stop entry.
module pss_flag_keep (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Control
    input  wire logic live_val,
    input  wire logic stop_enter,
    input  wire logic lost,
    input  wire logic regained,
    input  wire logic forced_val,
    // Result
    output logic      flag
);
    logic saved_q;
    logic pend_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            saved_q <= 1'b0;
            pend_q  <= 1'b0;
        end else begin
            if (stop_enter) saved_q <= live_val;
            // A fresh loss wins over a regain in the same cycle.
            if (lost) pend_q <= 1'b1;
            else if (regained) pend_q <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) flag <= 1'b0;
        else flag <= lost ? forced_val : (pend_q ? forced_val : saved_q);
    end
endmodule // pss_flag_keep
`default_nettype wire

// ===== pss_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pss_ctrl_asserts (
    // Clock and reset
    input wire logic                clk,
    input wire logic                arst_n,
    // Monitors and results
    input wire pss_pkg::pss_sense_t sense,
    input wire pss_pkg::pss_mode_t  clock_mode,
    input wire logic                reset_req,
    input wire logic                sticky_lock_flag,
    input wire logic                clock_loss_flag
);
    import pss_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_reset_one_pulse: assert property (reset_req |=> !reset_req)
        else $error("reset request held too long");
    chk_reset_has_cause: assert property (reset_req |-> $past(sense) != 3'h7)
        else $error("reset request without a loss");
    chk_self_mode_cause: assert property ($changed(clock_mode) &&
        clock_mode == PSS_SELF_CLOCKED_MODE |-> !$past(sense.ref_clk_ok))
        else $error("self-clocked mode without reference loss");
    chk_ref_mode_cause: assert property ($changed(clock_mode) &&
        clock_mode == PSS_REFERENCE_MODE |-> !($past(sense.fb_clk_ok) && $past(sense.pll_lock)))
        else $error("reference mode without loop loss");
    chk_lock_drop: assert property ($fell(sense.pll_lock) |=> !sticky_lock_flag)
        else $error("lock flag kept after lock loss");
    chk_lock_back_cause: assert property ($rose(sticky_lock_flag) |-> $past(sense.pll_lock))
        else $error("lock flag rose without lock");
    chk_loss_set: assert property ($fell(sense.ref_clk_ok) || $fell(sense.fb_clk_ok)
        |=> clock_loss_flag) else $error("clock-loss flag not set");
    chk_loss_clear_cause: assert property ($fell(clock_loss_flag) |->
        $past(sense.ref_clk_ok) && $past(sense.fb_clk_ok)) else $error("loss flag cleared early");
endmodule // pss_ctrl_asserts
bind pss_ctrl pss_ctrl_asserts pss_ctrl_asserts_inst (.clk(clk), .arst_n(arst_n),
    .sense(sense), .clock_mode(clock_mode), .reset_req(reset_req),
    .sticky_lock_flag(sticky_lock_flag), .clock_loss_flag(clock_loss_flag));
`default_nettype wire

// ===== pss_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module pss_ctrl_bench;
    import pss_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0, hwrite = 1'b0, stop_req = 1'b0, hrdy, hresp;
    logic        pll_on, osc_on, rst_rq, lk_f, ls_f;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, c;
    logic [31:0] seed = 32'h26;
    logic [1:0]  htrans = 2'h0;
    pss_sense_t  sense = 3'h7;
    pss_mode_t   clock_mode;
    pss_mode_t   em [2] = '{PSS_REFERENCE_MODE, PSS_SELF_CLOCKED_MODE};
    logic [2:0]  m [4] = '{3'h5, 3'h3, 3'h6, 3'h5};
    logic [7:0]  cf [4] = '{8'h04, 8'h04, 8'h14, 8'h0C};
    int          n_errors = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    pss_ctrl pss_ctrl_inst (.clk(clk), .arst_n(arst_n), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .stop_req(stop_req), .sense(sense),
        .pll_power_on(pll_on), .osc_power_on(osc_on), .clock_mode(clock_mode),
        .reset_req(rst_rq), .sticky_lock_flag(lk_f), .clock_loss_flag(ls_f));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [1:0] pwr(input logic [1:0] s);
        return {s < 2'h2, s != 2'h3};
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int i = 0;
        htrans <= 2'h2; haddr <= a; hwrite <= wr;
        do begin @(posedge clk); i++; end while (hrdy !== 1'b1 && i < 50);
        htrans <= 2'h0; hwdata <= d;
        do begin @(posedge clk); i++; end while (hrdy !== 1'b1 && i < 50);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
        if (i >= 50) begin n_errors++; give_verdict(); end
    endtask
    task automatic do_reset();
        arst_n <= 1'b0; sense <= 3'h7; stop_req <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic step2();
        repeat (2) @(posedge clk);
        #1;
    endtask
    initial begin
        do_reset();
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            c = {26'h0, seed[3:0], k[1:0]};
            bus(1'b1, 32'h0, c);
            bus(1'b0, 32'h0, 32'h0);
            `CHK("ctrl", c, rd)
            stop_req <= 1'b1;
            step2();
            `CHK("power", pwr(k[1:0]), {pll_on, osc_on})
            @(posedge clk);
            stop_req <= 1'b0;
        end
        bus(1'b0, 32'h40, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        // Without a crystal the oscillator enable stays low, in stop and out of it.
        bus(1'b1, 32'h0, 32'h43);
        #1;
        `CHK("osc_no_xtal", 1'b0, osc_on)
        stop_req <= 1'b1;
        step2();
        `CHK("power_no_xtal", 2'h0, {pll_on, osc_on})
        @(posedge clk);
        stop_req <= 1'b0;
        $display("test power done");
        for (int k = 0; k < 4; k++) begin
            do_reset();
            bus(1'b1, 32'h0, {24'h0, cf[k]});
            stop_req <= 1'b1;
            sense <= m[k];
            // The reset request stands for one cycle only, so look right after the loss.
            @(posedge clk);
            #1;
            `CHK("reset_req", k[1], rst_rq)
            if (!k[1]) begin
                `CHK("mode", em[k], clock_mode)
                `CHK("loss_flag", 1'b1, ls_f)
                @(posedge clk);
                bus(1'b0, 32'h4, 32'h0);
                `CHK("stat_mode", em[k], rd[3:2])
                sense <= 3'h7;
                step2();
                `CHK("loss_flag", 1'b0, ls_f)
            end
        end
        $display("test losses done");
        do_reset();
        bus(1'b1, 32'h0, 32'h4);
        stop_req <= 1'b1;
        // Lock goes one cycle into stop, so the value saved at entry is the locked one.
        @(posedge clk);
        sense <= 3'h6;
        repeat (8) @(posedge clk);
        #1;
        `CHK("lock_flag", 1'b0, lk_f)
        @(posedge clk);
        sense <= 3'h7;
        step2();
        `CHK("lock_flag", 1'b1, lk_f)
        $display("test lock flag done");
        give_verdict();
    end
endmodule // pss_ctrl_bench
`default_nettype wire
